// ---- include/gdm_pkg.sv ----
package gdm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_X_DATA_MASK   = 8'hc0;
  localparam logic [7:0]  ADDR_X_DIRECTION   = 8'hc6;
  localparam logic [7:0]  ADDR_Y_LOW_ODE     = 8'he2;
  localparam logic [7:0]  ADDR_Y_LOW_ODS     = 8'he3;
  localparam logic [7:0]  ADDR_Y_HIGH_ODE    = 8'he4;
  localparam logic [7:0]  ADDR_Y_HIGH_ODS    = 8'he5;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          X_DATA_LSB         = 0;
  localparam int          X_MASK_LSB         = 8;
  localparam int          X_WIDTH            = 8;
  localparam int          Y_LOW_WIDTH        = 8;
  localparam int          Y_HIGH_WIDTH       = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_X_DATA         = 8'hfc;
  localparam logic [7:0]  RST_X_MASK         = 8'h00;
  localparam logic [7:0]  RST_X_DIRECTION    = 8'h00;
  localparam logic [7:0]  RST_Y_LOW_ODE      = 8'h00;
  localparam logic [7:0]  RST_Y_LOW_ODS      = 8'h00;
  localparam logic [3:0]  RST_Y_HIGH_ODE     = 4'h8;
  localparam logic [3:0]  RST_Y_HIGH_ODS     = 4'h0;

endpackage

// ---- rtl/gdm_gpio_drive.sv ----
`timescale 1ns/1ns
module gdm_gpio_drive #(
  parameter int X_W  = gdm_pkg::X_WIDTH,
  parameter int YL_W = gdm_pkg::Y_LOW_WIDTH,
  parameter int YH_W = gdm_pkg::Y_HIGH_WIDTH
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Host register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  output logic                    reg_rvalid,
  // X-side pins
  input  wire logic [X_W-1:0]     x_side_pins_in,
  output logic      [X_W-1:0]     x_side_pins_out,
  output logic      [X_W-1:0]     x_side_pins_oe,
  // Y-side pins
  input  wire logic [YL_W+YH_W-1:0] y_side_level,
  input  wire logic [YL_W+YH_W-1:0] y_side_drive_en,
  output logic      [YL_W+YH_W-1:0] y_side_pins_out,
  output logic      [YL_W+YH_W-1:0] y_side_pins_oe
);

  // ----------------------------------------------------------------
  // Configuration and data state
  // ----------------------------------------------------------------
  logic [X_W-1:0]   x_out;
  logic [X_W-1:0]   x_mask;
  logic [X_W-1:0]   x_port_direction;
  logic [YL_W-1:0]  y_low_open_drain_enable;
  logic [YL_W-1:0]  y_low_drive_source_select;
  logic [YH_W-1:0]  y_high_open_drain_enable;
  logic [YH_W-1:0]  y_high_drive_source_select;
  logic [15:0]      rdata;
  logic             rvalid;

  logic [X_W-1:0]   next_x_out;
  logic [X_W-1:0]   next_x_mask;
  logic [X_W-1:0]   next_x_port_direction;
  logic [YL_W-1:0]  next_y_low_open_drain_enable;
  logic [YL_W-1:0]  next_y_low_drive_source_select;
  logic [YH_W-1:0]  next_y_high_open_drain_enable;
  logic [YH_W-1:0]  next_y_high_drive_source_select;
  logic [15:0]      next_rdata;
  logic             next_rvalid;
  logic [X_W-1:0]   x_read_level;
  logic [X_W-1:0]   wr_mask;
  logic [X_W-1:0]   wr_data;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign wr_mask = reg_wdata[gdm_pkg::X_MASK_LSB +: X_W];
  assign wr_data = reg_wdata[gdm_pkg::X_DATA_LSB +: X_W];
  // Output pins show their latch, input pins their live level
  assign x_read_level = (x_out & x_port_direction)
                      | (x_side_pins_in & ~x_port_direction);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb
  begin
    next_x_out                      = x_out;
    next_x_mask                     = x_mask;
    next_x_port_direction           = x_port_direction;
    next_y_low_open_drain_enable    = y_low_open_drain_enable;
    next_y_low_drive_source_select  = y_low_drive_source_select;
    next_y_high_open_drain_enable   = y_high_open_drain_enable;
    next_y_high_drive_source_select = y_high_drive_source_select;
    if (reg_wr)
    begin
      case (reg_addr)
        gdm_pkg::ADDR_X_DATA_MASK:
        begin
          next_x_mask = wr_mask;
          // Only unmasked output pins take the new level
          next_x_out  = (x_out & ~(wr_mask & x_port_direction))
                      | (wr_data & wr_mask & x_port_direction);
        end
        gdm_pkg::ADDR_X_DIRECTION:
          next_x_port_direction = reg_wdata[X_W-1:0];
        gdm_pkg::ADDR_Y_LOW_ODE:
          next_y_low_open_drain_enable = reg_wdata[YL_W-1:0];
        gdm_pkg::ADDR_Y_LOW_ODS:
          next_y_low_drive_source_select = reg_wdata[YL_W-1:0];
        gdm_pkg::ADDR_Y_HIGH_ODE:
          next_y_high_open_drain_enable = reg_wdata[YH_W-1:0];
        gdm_pkg::ADDR_Y_HIGH_ODS:
          next_y_high_drive_source_select = reg_wdata[YH_W-1:0];
        default:
        begin
          // Unmapped offsets are ignored
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      x_out                      <= gdm_pkg::RST_X_DATA;
      x_mask                     <= gdm_pkg::RST_X_MASK;
      x_port_direction           <= gdm_pkg::RST_X_DIRECTION;
      y_low_open_drain_enable    <= gdm_pkg::RST_Y_LOW_ODE;
      y_low_drive_source_select  <= gdm_pkg::RST_Y_LOW_ODS;
      y_high_open_drain_enable   <= gdm_pkg::RST_Y_HIGH_ODE;
      y_high_drive_source_select <= gdm_pkg::RST_Y_HIGH_ODS;
    end
    else
    begin
      x_out                      <= next_x_out;
      x_mask                     <= next_x_mask;
      x_port_direction           <= next_x_port_direction;
      y_low_open_drain_enable    <= next_y_low_open_drain_enable;
      y_low_drive_source_select  <= next_y_low_drive_source_select;
      y_high_open_drain_enable   <= next_y_high_open_drain_enable;
      y_high_drive_source_select <= next_y_high_drive_source_select;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Same-cycle write and read returns the old contents
  always_comb
  begin
    next_rdata  = rdata;
    next_rvalid = 1'b0;
    if (reg_rd)
    begin
      next_rvalid = 1'b1;
      case (reg_addr)
        gdm_pkg::ADDR_X_DATA_MASK:
          next_rdata = {x_mask, x_read_level};
        gdm_pkg::ADDR_X_DIRECTION:
          next_rdata = {8'h00, x_port_direction};
        gdm_pkg::ADDR_Y_LOW_ODE:
          next_rdata = {8'h00, y_low_open_drain_enable};
        gdm_pkg::ADDR_Y_LOW_ODS:
          next_rdata = {8'h00, y_low_drive_source_select};
        gdm_pkg::ADDR_Y_HIGH_ODE:
          next_rdata = {12'h000, y_high_open_drain_enable};
        gdm_pkg::ADDR_Y_HIGH_ODS:
          next_rdata = {12'h000, y_high_drive_source_select};
        default:
          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata       = rdata;
  assign reg_rvalid      = rvalid;
  // X side is always push-pull here; its drive mode lives elsewhere
  assign x_side_pins_out = x_out;
  assign x_side_pins_oe  = x_port_direction;

  // ----------------------------------------------------------------
  // Y-side output driver stage
  // ----------------------------------------------------------------
  logic [YL_W+YH_W-1:0] ode_all;
  logic [YL_W+YH_W-1:0] ods_all;
  assign ode_all = {y_high_open_drain_enable, y_low_open_drain_enable};
  assign ods_all = {y_high_drive_source_select, y_low_drive_source_select};

  generate
    for (genvar i = 0; i < YL_W + YH_W; i++)
    begin : g_ydrv
      // Open-drain releases the pin instead of driving the opposite rail
      always_comb
      begin
        if (!ode_all[i])
        begin
          y_side_pins_out[i] = y_side_level[i];
          y_side_pins_oe[i]  = y_side_drive_en[i];
        end
        else if (!ods_all[i])
        begin
          y_side_pins_out[i] = 1'b0;
          y_side_pins_oe[i]  = y_side_drive_en[i] & ~y_side_level[i];
        end
        else
        begin
          y_side_pins_out[i] = 1'b1;
          y_side_pins_oe[i]  = y_side_drive_en[i] & y_side_level[i];
        end
      end
    end
  endgenerate

endmodule

// ---- tb/gdm_asserts.sv ----
`timescale 1ns/1ns
module gdm_asserts #(
  parameter int X_W  = 8,
  parameter int YL_W = 8,
  parameter int YH_W = 4
) (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic [7:0]             reg_addr,
  input wire logic [15:0]            reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [15:0]            reg_rdata,
  input wire logic                   reg_rvalid,
  input wire logic [X_W-1:0]         x_side_pins_in,
  input wire logic [X_W-1:0]         x_side_pins_out,
  input wire logic [X_W-1:0]         x_side_pins_oe,
  input wire logic [YL_W+YH_W-1:0]   y_side_level,
  input wire logic [YL_W+YH_W-1:0]   y_side_drive_en,
  input wire logic [YL_W+YH_W-1:0]   y_side_pins_out,
  input wire logic [YL_W+YH_W-1:0]   y_side_pins_oe
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_read;
    reg_rd ##1 reg_rvalid;
  endsequence
  a_read_answer: assert property (reg_rd |-> s_read)
    else $error("read answer missing");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  a_y_level_kept: assert property
    ((y_side_pins_oe & (y_side_pins_out ^ y_side_level)) == 0)
    else $error("y pin drives wrong level");
  a_y_drive_gate: assert property ((y_side_pins_oe & ~y_side_drive_en) == 0)
    else $error("y pin driven without request");
  a_irq_open: assert property (!$past(rst_n) && y_side_level[11] |-> !y_side_pins_oe[11])
    else $error("interrupt ball not open drain");
  a_x_reset: assert property (!$past(rst_n) |->
    x_side_pins_out == gdm_pkg::RST_X_DATA && x_side_pins_oe == 0)
    else $error("x reset value wrong");
  a_x_masked: assert property ($changed(x_side_pins_out) |->
    $past(reg_wr) && $past(reg_addr) == gdm_pkg::ADDR_X_DATA_MASK)
    else $error("x output moved without write");
  a_x_write: assert property (reg_wr && reg_addr == gdm_pkg::ADDR_X_DATA_MASK |=>
    ((x_side_pins_out ^ $past(reg_wdata[7:0]))
      & $past(reg_wdata[15:8] & x_side_pins_oe)) == 0)
    else $error("unmasked x output not written");
  a_dir_write: assert property ($changed(x_side_pins_oe) |->
    $past(reg_wr) && $past(reg_addr) == gdm_pkg::ADDR_X_DIRECTION)
    else $error("x direction moved without write");
endmodule
bind gdm_gpio_drive gdm_asserts #(.X_W(X_W), .YL_W(YL_W), .YH_W(YH_W)) gdm_asserts_i (.*);

// ---- tb/gdm_host.sv ----
`timescale 1ns/1ns
module gdm_host (
  input  wire logic        clk_sys,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd
);
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // Released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// ---- tb/gdm_gpio_drive_test.sv ----
`timescale 1ns/1ns
module gdm_gpio_drive_test;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr, x_side_pins_out, x_side_pins_oe;
  logic [7:0]  x_side_pins_in = 8'h5a;
  logic [15:0] reg_wdata, reg_rdata, rd_data;
  logic        reg_wr, reg_rd, reg_rvalid, rd_v;
  logic [11:0] y_side_level = 12'hda5;
  logic [11:0] y_side_drive_en = 12'hfff;
  logic [11:0] y_side_pins_out, y_side_pins_oe;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  always #20 clk_sys = ~clk_sys;
  gdm_gpio_drive gdm_gpio_drive_i (.*);
  gdm_host gdm_host_i (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    gdm_host_i.rd(a, rd_data, rd_v);
    chk({15'h0, rd_v}, 16'h0001);
    chk(rd_data, exp);
  endtask
  task automatic ychk(input logic [11:0] open_drain_on, input logic [11:0] ods);
    logic [11:0] eo;
    logic [11:0] ee;
    #1;
    for (int i = 0; i < 12; i++)
    begin
      eo[i] = open_drain_on[i] ? ods[i] : y_side_level[i];
      ee[i] = y_side_drive_en[i] & (!open_drain_on[i] | (ods[i] == y_side_level[i]));
    end
    chk({4'h0, y_side_pins_out}, {4'h0, eo});
    chk({4'h0, y_side_pins_oe}, {4'h0, ee});
  endtask
  task automatic t_reset;
    chk({8'h0, x_side_pins_out}, 16'h00fc);
    rchk(8'hc0, 16'h005a);
    rchk(8'hc6, 16'h0000);
    rchk(8'he2, 16'h0000);
    rchk(8'he3, 16'h0000);
    rchk(8'he4, 16'h0008);
    rchk(8'he5, 16'h0000);
    rchk(8'he7, 16'h0000);
    ychk(12'h800, 12'h000);
  endtask
  task automatic t_x;
    gdm_host_i.wr(8'hc6, 16'h000f);
    gdm_host_i.wr(8'hc0, 16'h33aa);
    chk({8'h0, x_side_pins_out}, 16'h00fe);
    chk({8'h0, x_side_pins_oe}, 16'h000f);
    rchk(8'hc0, 16'h335e);
    x_side_pins_in = 8'ha5;
    rchk(8'hc0, 16'h33ae);
    gdm_host_i.wr(8'hc0, 16'h0001);
    chk({8'h0, x_side_pins_out}, 16'h00fe);
  endtask
  task automatic t_y;
    gdm_host_i.wr(8'he2, 16'h00f0);
    gdm_host_i.wr(8'he3, 16'h00cc);
    gdm_host_i.wr(8'he4, 16'h00f3);
    gdm_host_i.wr(8'he5, 16'h00f6);
    rchk(8'he4, 16'h0003);
    rchk(8'he5, 16'h0006);
    repeat (2)
    begin
      ychk(12'h3f0, 12'h6cc);
      @(posedge clk_sys) #1;
      y_side_level = ~y_side_level;
      y_side_drive_en = 12'h3c3;
    end
  endtask
  task automatic t_reset_mid;
    @(posedge clk_sys) #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk({8'h0, x_side_pins_out}, 16'h00fc);
    chk({8'h0, x_side_pins_oe}, 16'h0000);
    rchk(8'hc0, 16'h00a5);
    rchk(8'he2, 16'h0000);
    rchk(8'he3, 16'h0000);
    rchk(8'he4, 16'h0008);
    rchk(8'he5, 16'h0000);
    ychk(12'h800, 12'h000);
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset;
    t_x;
    t_y;
    t_reset_mid;
    end_of_test;
  end
endmodule
